// file: core/system_clock_watchdog_reset_ctrl.sv
// The AXI4-Lite slave port and the register offsets were left to the implementer.
module system_clock_watchdog_reset_ctrl
  import sysctl_pkg::*;
#(
  parameter logic [DIV_W-1:0]  LRC_DIV         = 16'h0708,
  parameter logic [WAKE_W-1:0] SLOW_WAKE_TICKS = 12'h400
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  // axi4-lite read data
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // pins and analog
  input  wire logic              shared_reset_pin,
  input  wire logic              lv_detect,
  input  wire logic              fast_boot_sel,
  // cpu side
  input  wire logic              wdt_clear_req,
  input  wire logic              wake_req,
  output logic                   cpu_run,
  output logic                   sys_reset_n,
  // clocking and watchdog
  output logic                   system_clock_en,
  output logic                   low_speed_rc_osc_tick,
  output logic                   low_speed_rc_osc_en,
  output logic                   high_speed_rc_osc_en,
  output logic                   wdt_timeout
);

  // pin synchronisers
  logic [1:0] pin_sync_ff;
  logic [1:0] nxt_pin_sync;
  logic [1:0] lv_sync_ff;
  logic [1:0] nxt_lv_sync;

  always_comb begin
    nxt_pin_sync = {pin_sync_ff[0], shared_reset_pin};
    nxt_lv_sync  = {lv_sync_ff[0], lv_detect};
  end

  // pin idles high so reset does not fire on release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync_ff <= 2'h3;
      lv_sync_ff  <= 2'h0;
    end else begin
      pin_sync_ff <= nxt_pin_sync;
      lv_sync_ff  <= nxt_lv_sync;
    end
  end

  // axi write channel
  logic              aw_hold_ff;
  logic              nxt_aw_hold;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [ADDR_W-1:0] nxt_aw_addr;
  logic              w_hold_ff;
  logic              nxt_w_hold;
  logic [DATA_W-1:0] w_data_ff;
  logic [DATA_W-1:0] nxt_w_data;
  logic [3:0]        w_strb_ff;
  logic [3:0]        nxt_w_strb;
  logic              bvalid_ff;
  logic              nxt_bvalid;
  logic [1:0]        bresp_ff;
  logic [1:0]        nxt_bresp;
  logic              aw_take;
  logic              w_take;
  logic              wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_lane0;
  logic              wr_mapped;

  assign awready = !aw_hold_ff && !bvalid_ff;
  assign wready  = !w_hold_ff && !bvalid_ff;

  always_comb begin
    aw_take   = awvalid && awready;
    w_take    = wvalid && wready;
    wr_addr   = aw_hold_ff ? aw_addr_ff : awaddr;
    wr_data   = w_hold_ff ? w_data_ff : wdata;
    wr_lane0  = w_hold_ff ? w_strb_ff[WSTRB_LANE0] : wstrb[WSTRB_LANE0];
    wr_fire   = (aw_hold_ff || aw_take) && (w_hold_ff || w_take)
                && !bvalid_ff;
    wr_mapped = (wr_addr == CLOCK_MODE_OFS) || (wr_addr == MISC_OFS) ||
                (wr_addr == WDT_CTRL_OFS) || (wr_addr == STATUS_OFS) ||
                (wr_addr == WDT_COUNT_OFS);
    nxt_aw_hold = wr_fire ? 1'b0 : (aw_hold_ff || aw_take);
    nxt_w_hold  = wr_fire ? 1'b0 : (w_hold_ff || w_take);
    nxt_aw_addr = aw_take ? awaddr : aw_addr_ff;
    nxt_w_data  = w_take ? wdata : w_data_ff;
    nxt_w_strb  = w_take ? wstrb : w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (wr_fire) begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_hold_ff  <= 1'b0;
      w_data_ff  <= '0;
      w_strb_ff  <= '0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_hold_ff  <= nxt_w_hold;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp  = bresp_ff;

  // write strobes into the control registers
  logic wr_cm;
  logic wr_misc;
  logic wr_wdt_clear;
  logic wr_status;

  always_comb begin
    wr_cm        = wr_fire && wr_lane0 && (wr_addr == CLOCK_MODE_OFS);
    wr_misc      = wr_fire && wr_lane0 && (wr_addr == MISC_OFS);
    wr_wdt_clear = wr_fire && wr_lane0 && (wr_addr == WDT_CTRL_OFS) &&
                   wr_data[WC_CLEAR_BIT];
    wr_status    = wr_fire && wr_lane0 && (wr_addr == STATUS_OFS);
  end

  // control registers and reset cause
  rst_state_t         state_ff;
  rst_state_t         nxt_state;
  logic [REG_W-1:0]   cmode_ff;
  logic [REG_W-1:0]   nxt_cmode;
  logic [REG_W-1:0]   misc_ff;
  logic [REG_W-1:0]   nxt_misc;
  logic [CAUSE_W-1:0] cause_ff;
  logic [CAUSE_W-1:0] nxt_cause;
  logic [CAUSE_W-1:0] cause_set;
  logic               in_reset;
  logic               pin_rst;
  logic               lv_rst;
  logic               rst_req;

  always_comb begin
    in_reset = (state_ff == ST_RESET);
    pin_rst  = cmode_ff[CM_RST_PIN_BIT] && !pin_sync_ff[1];
    lv_rst   = !misc_ff[MISC_LV_DIS] && lv_sync_ff[1];
    rst_req  = wdt_timeout || pin_rst || lv_rst;
    cause_set = '0;
    cause_set[CAUSE_WDT] = wdt_timeout;
    cause_set[CAUSE_PIN] = pin_rst;
    cause_set[CAUSE_LV]  = lv_rst;
    // a full system reset restores the control registers
    if (in_reset) begin
      nxt_cmode = CLOCK_MODE_RST;
      nxt_misc  = MISC_RST;
    end else begin
      nxt_cmode = wr_cm ? wr_data[REG_W-1:0] : cmode_ff;
      nxt_misc  = wr_misc ? wr_data[REG_W-1:0] : misc_ff;
    end
    // cause survives the soft reset; a new event beats a w1c
    nxt_cause = cause_ff;
    if (wr_status) begin
      nxt_cause = cause_ff & ~wr_data[ST_CAUSE_LSB +: CAUSE_W];
    end
    nxt_cause = nxt_cause | cause_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmode_ff <= CLOCK_MODE_RST;
      misc_ff  <= MISC_RST;
      cause_ff <= '0;
    end else begin
      cmode_ff <= nxt_cmode;
      misc_ff  <= nxt_misc;
      cause_ff <= nxt_cause;
    end
  end

  // clock source selection
  logic                src_lrc;
  logic [CM_SEL_W-1:0] clk_sel;
  logic [DIV_W-1:0]    sys_div;
  logic                lrc_run;
  logic                hrc_run;
  logic                sys_src_tick;

  // an oscillator feeding the system clock cannot be stopped;
  // firmware can switch source and stop the old oscillator in one write
  always_comb begin
    src_lrc = cmode_ff[CM_SRC_LRC_BIT];
    clk_sel = cmode_ff[CM_SEL_LSB +: CM_SEL_W];
    sys_div = src_lrc ? LRC_DIV_TAB[clk_sel] : HRC_DIV_TAB[clk_sel];
    lrc_run = cmode_ff[CM_LRC_EN_BIT] || src_lrc ||
              (state_ff == ST_WAKE);
    hrc_run = cmode_ff[CM_HRC_EN_BIT] || !src_lrc;
    sys_src_tick = src_lrc ? low_speed_rc_osc_tick : hrc_run;
  end

  clk_en_div u_lrc_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .restart  (!lrc_run),
    .src_tick (lrc_run),
    .div      (LRC_DIV),
    .tick     (low_speed_rc_osc_tick)
  );

  // restart on every mode write so the new rate starts cleanly
  clk_en_div u_sys_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .restart  (wr_cm),
    .src_tick (sys_src_tick),
    .div      (sys_div),
    .tick     (system_clock_en)
  );

  assign low_speed_rc_osc_en  = lrc_run;
  assign high_speed_rc_osc_en = hrc_run;

  // watchdog
  logic [WDT_W-1:0] wdt_count;

  wdt_counter u_wdt (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .enable     (cmode_ff[CM_WDT_EN_BIT] && (state_ff == ST_RUN)),
    .tick       (low_speed_rc_osc_tick),
    .clear      (wdt_clear_req || wr_wdt_clear),
    .period_sel (misc_ff[MISC_WDT_LSB +: MISC_WDT_W]),
    .timeout    (wdt_timeout),
    .count      (wdt_count)
  );

  // reset and wake-up sequencer
  logic [HOLD_W-1:0] hold_cnt_ff;
  logic [HOLD_W-1:0] nxt_hold_cnt;
  logic [WAKE_W-1:0] wake_cnt_ff;
  logic [WAKE_W-1:0] nxt_wake_cnt;
  logic [WAKE_W-1:0] wake_last;

  always_comb begin
    wake_last = (fast_boot_sel ? FAST_WAKE_TICKS : SLOW_WAKE_TICKS)
                - WAKE_W'(1);
    nxt_state    = state_ff;
    nxt_hold_cnt = hold_cnt_ff;
    nxt_wake_cnt = wake_cnt_ff;
    case (state_ff)
      ST_RESET: begin
        if (hold_cnt_ff == HOLD_W'(RESET_HOLD_CYC - 1)) begin
          nxt_state    = ST_WAKE;
          nxt_wake_cnt = '0;
        end else begin
          nxt_hold_cnt = hold_cnt_ff + HOLD_W'(1);
        end
      end
      ST_WAKE: begin
        if (low_speed_rc_osc_tick) begin
          if (wake_cnt_ff >= wake_last) begin
            nxt_state = ST_RUN;
          end else begin
            nxt_wake_cnt = wake_cnt_ff + WAKE_W'(1);
          end
        end
      end
      ST_RUN: begin
        if (wake_req) begin
          nxt_state    = ST_WAKE;
          nxt_wake_cnt = '0;
        end
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
    // any reset source restarts the hold from the top
    if (rst_req) begin
      nxt_state    = ST_RESET;
      nxt_hold_cnt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff    <= ST_RESET;
      hold_cnt_ff <= '0;
      wake_cnt_ff <= '0;
    end else begin
      state_ff    <= nxt_state;
      hold_cnt_ff <= nxt_hold_cnt;
      wake_cnt_ff <= nxt_wake_cnt;
    end
  end

  assign sys_reset_n = !in_reset;
  assign cpu_run     = (state_ff == ST_RUN);

  // axi read channel
  logic              rvalid_ff;
  logic              nxt_rvalid;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [1:0]        rresp_ff;
  logic [1:0]        nxt_rresp;
  logic [REG_W-1:0]  status;

  assign arready = !rvalid_ff;

  always_comb begin
    status = '0;
    status[ST_LRC_RUN]   = lrc_run;
    status[ST_HRC_RUN]   = hrc_run;
    status[ST_CPU_RUN]   = cpu_run;
    status[ST_WAKE_BUSY] = (state_ff == ST_WAKE);
    status[ST_CAUSE_LSB +: CAUSE_W] = cause_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (arvalid && arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      case (araddr)
        CLOCK_MODE_OFS: nxt_rdata = DATA_W'(cmode_ff);
        MISC_OFS:       nxt_rdata = DATA_W'(misc_ff);
        WDT_CTRL_OFS:   nxt_rdata = '0;
        STATUS_OFS:     nxt_rdata = DATA_W'(status);
        WDT_COUNT_OFS:  nxt_rdata = DATA_W'(wdt_count);
        default: begin
          nxt_rdata = '0;
          nxt_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata  = rdata_ff;
  assign rresp  = rresp_ff;

endmodule

// file: core/sysctl_pkg.sv
package sysctl_pkg;

  // register bus
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 32;
  localparam int          REG_W         = 8;
  localparam int          WSTRB_LANE0   = 0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // register map (byte addresses)
  localparam logic [ADDR_W-1:0] CLOCK_MODE_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] MISC_OFS       = 5'h04;
  localparam logic [ADDR_W-1:0] WDT_CTRL_OFS   = 5'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS     = 5'h0c;
  localparam logic [ADDR_W-1:0] WDT_COUNT_OFS  = 5'h10;

  // clock_mode_reg fields
  localparam int CM_RST_PIN_BIT = 0;
  localparam int CM_WDT_EN_BIT  = 1;
  localparam int CM_LRC_EN_BIT  = 2;
  localparam int CM_SRC_LRC_BIT = 3;
  localparam int CM_HRC_EN_BIT  = 4;
  localparam int CM_SEL_LSB     = 5;
  localparam int CM_SEL_W       = 3;
  localparam logic [REG_W-1:0] CLOCK_MODE_RST = 8'h0c;

  // misc fields
  localparam int MISC_WDT_LSB   = 0;
  localparam int MISC_WDT_W     = 2;
  localparam int MISC_LV_DIS    = 2;
  localparam logic [REG_W-1:0] MISC_RST = 8'h00;

  // watchdog control and status fields
  localparam int WC_CLEAR_BIT   = 0;
  localparam int ST_LRC_RUN     = 0;
  localparam int ST_HRC_RUN     = 1;
  localparam int ST_CPU_RUN     = 2;
  localparam int ST_WAKE_BUSY   = 3;
  localparam int ST_CAUSE_LSB   = 4;
  localparam int CAUSE_W        = 3;
  localparam int CAUSE_WDT      = 0;
  localparam int CAUSE_PIN      = 1;
  localparam int CAUSE_LV       = 2;

  // dividers
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
  localparam logic [DIV_W-1:0] HRC_DIV_TAB [8] = '{
    16'h0004, 16'h0002, 16'h0001, 16'h0010,
    16'h0008, 16'h0020, 16'h0040, 16'h0080};
  localparam logic [DIV_W-1:0] LRC_DIV_TAB [8] = '{
    16'h0001, 16'h0010, 16'h0004, 16'h0004,
    16'h0004, 16'h0004, 16'h0004, 16'h0004};

  // watchdog: last count before expiry, in slow periods
  localparam int WDT_W = 18;
  localparam logic [WDT_W-1:0] WDT_LIMIT_TAB [4] = '{
    18'h01fff, 18'h03fff, 18'h0ffff, 18'h3ffff};

  // timing
  localparam int WAKE_W          = 12;
  localparam logic [WAKE_W-1:0] FAST_WAKE_TICKS = 12'h02d;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RESET_HOLD_NS   = 100;
  localparam int RESET_HOLD_CYC  =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W          = 8;

  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_WAKE  = 3'b010,
    ST_RUN   = 3'b100
  } rst_state_t;

endpackage

// file: core/clk_en_div.sv
module clk_en_div
  import sysctl_pkg::*;
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control
  input  wire logic             restart,
  input  wire logic             src_tick,
  input  wire logic [DIV_W-1:0] div,
  // output enable pulse
  output logic                  tick
);

  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] nxt_cnt;
  logic             tick_ff;
  logic             nxt_tick;
  logic [DIV_W-1:0] last;

  // a zero divisor behaves as divide by one
  always_comb begin
    last     = (div == '0) ? '0 : div - DIV_ONE;
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (restart) begin
      nxt_cnt = '0;
    end else if (src_tick) begin
      if (cnt_ff >= last) begin
        nxt_cnt  = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + DIV_ONE;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule

// file: core/wdt_counter.sv
module wdt_counter
  import sysctl_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // control
  input  wire logic                  enable,
  input  wire logic                  tick,
  input  wire logic                  clear,
  input  wire logic [MISC_WDT_W-1:0] period_sel,
  // status
  output logic                       timeout,
  output logic [WDT_W-1:0]           count
);

  logic [WDT_W-1:0] cnt_ff;
  logic [WDT_W-1:0] nxt_cnt;
  logic             to_ff;
  logic             nxt_to;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_to  = 1'b0;
    if (clear || !enable) begin
      nxt_cnt = '0;
    end else if (tick) begin
      if (cnt_ff >= WDT_LIMIT_TAB[period_sel]) begin
        nxt_cnt = '0;
        nxt_to  = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + WDT_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
      to_ff  <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      to_ff  <= nxt_to;
    end
  end

  assign timeout = to_ff;
  assign count   = cnt_ff;

endmodule

// file: verif/sysctl_chk.sv
module sysctl_chk
  import sysctl_pkg::*;
(
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // register bus
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              rvalid,
  input wire logic              rready,
  // control and status
  input wire logic              fast_boot_sel,
  input wire logic              cpu_run,
  input wire logic              sys_reset_n,
  input wire logic              low_speed_rc_osc_tick,
  input wire logic              low_speed_rc_osc_en,
  input wire logic              wdt_timeout
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [7:0] wake_ff;
  logic [7:0] nxt_wake;

  // slow ticks seen since the core last left run or reset
  always_comb begin
    nxt_wake = wake_ff;
    if (!sys_reset_n || cpu_run)
      nxt_wake = 8'h00;
    else if (low_speed_rc_osc_tick)
      nxt_wake = wake_ff + 8'h01;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      wake_ff <= 8'h00;
    else
      wake_ff <= nxt_wake;
  end

  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_osc_off;
    !low_speed_rc_osc_en [*3];
  endsequence

  property p_b_lat;
    s_wr_take |=> bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_lat;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_busy;
    rvalid |-> !arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read taken early");
  property p_tick_off;
    !low_speed_rc_osc_en [*2] |-> !low_speed_rc_osc_tick;
  endproperty
  a_tick_off: assert property (p_tick_off)
    else $error("slow tick while stopped");
  property p_wdt_off;
    s_osc_off |-> !wdt_timeout;
  endproperty
  a_wdt_off: assert property (p_wdt_off)
    else $error("watchdog fired while stopped");
  property p_wake;
    $rose(cpu_run) && fast_boot_sel |-> wake_ff == 8'h2d;
  endproperty
  a_wake: assert property (p_wake)
    else $error("fast wake length wrong");
  property p_wdt_rst;
    wdt_timeout |-> cpu_run ##2 !sys_reset_n [*6];
  endproperty
  a_wdt_rst: assert property (p_wdt_rst)
    else $error("watchdog gave no reset");
endmodule

bind system_clock_watchdog_reset_ctrl sysctl_chk u_chk (.*);

// file: verif/fw_axi.sv
module fw_axi
  import sysctl_pkg::*;
(
  // clock
  input  wire logic              aclk,
  // write channels
  output logic [ADDR_W-1:0]      awaddr,
  output logic [2:0]             awprot,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic [DATA_W-1:0]      wdata,
  output logic [3:0]             wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output logic                   bready,
  // read channels
  output logic [ADDR_W-1:0]      araddr,
  output logic [2:0]             arprot,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output logic                   rready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    awaddr  = '0;
    awprot  = 3'h0;
    awvalid = 1'b0;
    wdata   = '0;
    wstrb   = 4'hf;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = '0;
    arprot  = 3'h0;
    arvalid = 1'b0;
    rready  = 1'b0;
  end

  // released payload is inverted so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a,
                    output logic [DATA_W-1:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// file: verif/tb_top.sv
module tb_top import sysctl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn, shared_reset_pin, lv_detect, fast_boot_sel;
  logic wdt_clear_req, wake_req, cpu_run, sys_reset_n, wdt_timeout;
  logic system_clock_en, low_speed_rc_osc_tick;
  logic low_speed_rc_osc_en, high_speed_rc_osc_en;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [2:0]        awprot, arprot;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [31:0]       mdl [3];
  int                fails, checked, seed, t, k, v;

  always #5 aclk = ~aclk;

  // short slow period and wake keep the run small
  system_clock_watchdog_reset_ctrl #(
    .LRC_DIV(16'h0004),
    .SLOW_WAKE_TICKS(12'h004)
  ) u_dut (.*);
  fw_axi u_fw (.*);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [1:0] r;
    u_fw.wr(a, {24'h0, d}, r);
    check(r, (a > WDT_COUNT_OFS) ? RESP_SLVERR : RESP_OKAY);
    if (a < STATUS_OFS)
      mdl[a[4:2]] = (a == WDT_CTRL_OFS) ? 32'h0 : {24'h0, d};
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    u_fw.rd(a, d, r);
    check(d, exp);
    check(r, (a > WDT_COUNT_OFS) ? RESP_SLVERR : RESP_OKAY);
  endtask

  task automatic mreset();
    mdl[0] = {24'h0, CLOCK_MODE_RST};
    mdl[1] = {24'h0, MISC_RST};
    mdl[2] = 32'h0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic gap(input int exp);
    int n;
    n = 0;
    do @(posedge aclk); while (!system_clock_en && n++ < 999);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!system_clock_en && n < 999);
    check(n, exp);
  endtask

  // slow ticks spent waking, then the core must be running
  task automatic boot(output int s);
    int j;
    s = 0;
    j = 0;
    do begin
      @(posedge aclk);
      j++;
      if (sys_reset_n && !cpu_run && low_speed_rc_osc_tick)
        s++;
    end while (!cpu_run && j < 2000);
    check(cpu_run, 1'b1);
  endtask

  task automatic clr_pulse();
    wdt_clear_req <= 1'b1;
    cyc(1);
    wdt_clear_req <= 1'b0;
  endtask

  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    summarize();
  end

  initial begin
    seed = 32'he804;
    aresetn = 1'b0;
    shared_reset_pin = 1'b1;
    lv_detect = 1'b0;
    fast_boot_sel = 1'b0;
    wdt_clear_req = 1'b0;
    wake_req = 1'b0;
    mreset();
    cyc(6);
    aresetn <= 1'b1;
    rd(CLOCK_MODE_OFS, mdl[0]);
    rd(MISC_OFS, mdl[1]);
    boot(t);
    wr(5'h14, 8'hff);
    rd(5'h14, 32'h0);
    repeat (4) begin
      v = $random(seed);
      wr(MISC_OFS, {5'h0, v[2:0]});
      rd(MISC_OFS, mdl[1]);
    end
    $display("test registers done");
    wr(CLOCK_MODE_OFS, 8'h36);
    gap(2);
    check(low_speed_rc_osc_en, 1'b1);
    check(high_speed_rc_osc_en, 1'b1);
    wr(CLOCK_MODE_OFS, 8'h32);
    cyc(4);
    check(low_speed_rc_osc_en, 1'b0);
    clr_pulse();
    wr(WDT_CTRL_OFS, 8'h01);
    cyc(200);
    rd(WDT_COUNT_OFS, 32'h0);
    wr(CLOCK_MODE_OFS, 8'h36);
    wr(CLOCK_MODE_OFS, 8'h3c);
    wr(CLOCK_MODE_OFS, 8'h2c);
    gap(64);
    wr(CLOCK_MODE_OFS, 8'h0c);
    gap(4);
    $display("test clocks done");
    wr(MISC_OFS, 8'h00);
    wr(CLOCK_MODE_OFS, 8'h0e);
    k = 0;
    do @(posedge aclk); while (!low_speed_rc_osc_tick && k++ < 99);
    clr_pulse();
    t = 0;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (low_speed_rc_osc_tick)
        t++;
    end while (!wdt_timeout && k < 40000);
    check(t, 8192);
    cyc(3);
    check(sys_reset_n, 1'b0);
    mreset();
    boot(t);
    rd(CLOCK_MODE_OFS, mdl[0]);
    // cause bit for watchdog kept, slow osc and core running
    rd(STATUS_OFS, 32'h15);
    wr(STATUS_OFS, 8'h10);
    rd(STATUS_OFS, 32'h05);
    $display("test watchdog done");
    wr(MISC_OFS, 8'h04);
    lv_detect <= 1'b1;
    cyc(20);
    check(sys_reset_n, 1'b1);
    wr(MISC_OFS, 8'h00);
    cyc(6);
    check(sys_reset_n, 1'b0);
    lv_detect <= 1'b0;
    mreset();
    boot(t);
    shared_reset_pin <= 1'b0;
    cyc(20);
    check(sys_reset_n, 1'b1);
    shared_reset_pin <= 1'b1;
    fast_boot_sel <= 1'b1;
    wr(CLOCK_MODE_OFS, 8'h0d);
    shared_reset_pin <= 1'b0;
    cyc(6);
    check(sys_reset_n, 1'b0);
    shared_reset_pin <= 1'b1;
    mreset();
    boot(t);
    check(t, 45);
    wake_req <= 1'b1;
    cyc(1);
    wake_req <= 1'b0;
    boot(t);
    check(t, 45);
    $display("test resets done");
    summarize();
  end
endmodule
